// File: pkg/sfph_pkg.sv
// shared constants and types for the flash power and pause controller
package sfph_pkg;

  // =====================================================================
  // opcodes
  localparam logic [7:0] SFPH_OPC_POWERDOWN = 8'hB9;
  localparam logic [7:0] SFPH_OPC_RESUME    = 8'hAB;

  // =====================================================================
  // framing
  localparam int         SFPH_BYTE_BITS = 8;
  localparam int         SFPH_BCNT_W    = 3;
  localparam logic [2:0] SFPH_BCNT_RST  = 3'h0;
  localparam logic [2:0] SFPH_BCNT_LAST = 3'(SFPH_BYTE_BITS - 1);
  localparam logic [7:0] SFPH_BYTE_RST  = 8'h00;

  // =====================================================================
  // timing, longest times rounded down to whole cycles
  localparam int SFPH_CLK_PERIOD_NS             = 10;
  localparam int SFPH_POWERDOWN_ENTRY_TIME_NS   = 1000;
  localparam int SFPH_POWERDOWN_EXIT_TIME_NS    = 3000;
  localparam int SFPH_ENTRY_RAW = SFPH_POWERDOWN_ENTRY_TIME_NS / SFPH_CLK_PERIOD_NS;
  localparam int SFPH_EXIT_RAW  = SFPH_POWERDOWN_EXIT_TIME_NS / SFPH_CLK_PERIOD_NS;
  localparam int SFPH_ENTRY_CYC = (SFPH_ENTRY_RAW < 1) ? 1 : SFPH_ENTRY_RAW;
  localparam int SFPH_EXIT_CYC  = (SFPH_EXIT_RAW < 1) ? 1 : SFPH_EXIT_RAW;
  localparam int SFPH_CNT_W     = 9;
  localparam logic [8:0] SFPH_ENTRY_LOAD = 9'(SFPH_ENTRY_CYC - 1);
  localparam logic [8:0] SFPH_EXIT_LOAD  = 9'(SFPH_EXIT_CYC - 1);
  localparam logic [8:0] SFPH_CNT_RST    = 9'h000;

  // =====================================================================
  // synchronised pin bundle
  localparam int SFPH_PIN_CS   = 0;
  localparam int SFPH_PIN_SCK  = 1;
  localparam int SFPH_PIN_SI   = 2;
  localparam int SFPH_PIN_HOLD = 3;
  localparam int SFPH_PIN_WP   = 4;
  localparam int SFPH_NPINS    = 5;
  localparam logic [4:0] SFPH_PINS_RST = 5'h1B; // idle: cs, hold, wp, sck high

  // =====================================================================
  // power states
  typedef enum logic [3:0] {
    SFPH_PWR_STANDBY = 4'h1,
    SFPH_PWR_ENTER   = 4'h2,
    SFPH_PWR_DEEP    = 4'h4,
    SFPH_PWR_EXIT    = 4'h8
  } sfph_pwr_t;
  localparam sfph_pwr_t SFPH_PWR_RST = SFPH_PWR_STANDBY;

endpackage

// File: tb/sfph_ctrl_tb.sv
// self-checking bench for the flash power and pause controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sfph_ctrl_tb;
  import sfph_pkg::*;
  logic        clk_i;
  logic        nrst_i;
  logic        busy_i;
  logic        so_data_i;
  logic        so_en_i;
  logic        en_fix    = 1'b0;
  logic        mon_on    = 1'b0;
  logic        dat_d;
  logic        en_d;
  logic [31:0] rs        = 32'h65227F73;
  wire logic   cs_n, sck, si, hold_n, wp_n;
  logic        so_o, so_oe_n_o, core_bit_stb_o, core_bit_o, core_frame_end_o, wp_n_o;
  logic        standby_o, deep_pd_o, paused_o, ready_busy_flag_o, wel_clear_o, op_abort_o;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          nstb        = 0;
  int          n_wel       = 0;
  int          n_abt       = 0;
  int          n_fe        = 0;
  logic [15:0] bits        = 16'h0000;
  logic [31:0] seed        = 32'h65227F73;
  logic        deep_exp    = 1'b0;
  localparam int NT = 10;
  // corner cases, one busy refusal then the reissue
  logic [7:0]  t_opc [NT] = '{SFPH_OPC_POWERDOWN, 8'h05, SFPH_OPC_RESUME, SFPH_OPC_RESUME, SFPH_OPC_RESUME,
    SFPH_OPC_POWERDOWN, SFPH_OPC_POWERDOWN, SFPH_OPC_POWERDOWN, SFPH_OPC_POWERDOWN, SFPH_OPC_RESUME};
  int          t_nb [NT]  = '{16, 8, 7, 12, 16, 7, 12, 8, 8, 8};
  logic        t_bsy [NT] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0};
  int          t_nbr [4]  = '{7, 8, 12, 16};

  sfph_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n),
    .wp_n_i(wp_n), .busy_i(busy_i), .so_data_i(so_data_i), .so_en_i(so_en_i), .so_o(so_o),
    .so_oe_n_o(so_oe_n_o), .core_bit_stb_o(core_bit_stb_o), .core_bit_o(core_bit_o),
    .core_frame_end_o(core_frame_end_o), .wp_n_o(wp_n_o), .standby_o(standby_o), .deep_pd_o(deep_pd_o),
    .paused_o(paused_o), .ready_busy_flag_o(ready_busy_flag_o), .wel_clear_o(wel_clear_o),
    .op_abort_o(op_abort_o));
  sfph_host host (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n), .wp_n_o(wp_n));

  // =====================================================================
  // clock, output data toggling, monitor
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // random core data and enable; the pause scenario pins the enable high
  always @(posedge clk_i) begin
    rs        <= xs(rs);
    so_data_i <= rs[0];
    so_en_i   <= rs[1] | en_fix;
    dat_d     <= so_data_i;
    en_d      <= so_en_i;
  end

  // counts strobes and abort pulses; deep state must keep the output floating
  always @(posedge clk_i) begin
    if (core_bit_stb_o === 1'b1) begin
      nstb <= nstb + 1;
      bits <= {bits[14:0], core_bit_o};
    end
    n_wel <= n_wel + int'(wel_clear_o === 1'b1);
    n_abt <= n_abt + int'(op_abort_o === 1'b1);
    n_fe  <= n_fe + int'(core_frame_end_o === 1'b1);
    if (deep_pd_o === 1'b1) `CHK(so_oe_n_o, 1'b1)
    // output data is the core bit one cycle late; a quiet core never drives
    if (mon_on) begin
      `CHK(so_o, dat_d)
      if (en_d === 1'b0) `CHK(so_oe_n_o, 1'b1)
    end
  end

  // =====================================================================
  // expectations and scenarios
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // power state after a frame; partial bytes never count
  function automatic logic next_deep(input logic dp, input logic [7:0] opc, input int nb, input logic b);
    logic ok;
    ok = (nb >= 8) && (nb % 8 == 0);
    if (dp) return !(ok && opc == SFPH_OPC_RESUME);
    return ok && !b && opc == SFPH_OPC_POWERDOWN;
  endfunction

  task automatic run_case(input logic [7:0] opc, input int nb, input logic b);
    logic [15:0] d;
    logic        exp;
    int          n0;
    int          f0;
    seed = xs(seed);
    d    = {opc, seed[7:0]};
    exp  = next_deep(deep_exp, opc, nb, b);
    n0   = nstb;
    f0   = n_fe;
    @(posedge clk_i);
    busy_i <= b;
    host.frame(d, nb);
    busy_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(nstb - n0, deep_exp ? 0 : nb)
    `CHK(n_fe - f0, deep_exp ? 0 : 1)
    if (!deep_exp) `CHK(bits & (16'hFFFF >> (16 - nb)), d >> (16 - nb))
    `CHK(deep_pd_o, exp)
    `CHK(standby_o, ~exp)
    deep_exp = exp;
  endtask

  // pause entry in both clock phases, exit only released in the high phase, then deselect while paused
  task automatic pause_case();
    int n0;
    en_fix <= 1'b1;
    host.set_hold(1'b0);
    repeat (8) @(posedge clk_i);
    `CHK(paused_o, 1'b0)
    host.set_hold(1'b1);
    n0 = nstb;
    host.sel();
    for (int i = 0; i < 3; i++) host.bit_out(seed[i]);
    host.set_sck(1'b0);
    `CHK(so_oe_n_o, 1'b0)
    busy_i <= 1'b1;
    host.set_hold(1'b0);
    repeat (8) @(posedge clk_i);
    `CHK(paused_o, 1'b1)
    `CHK(so_oe_n_o, 1'b1)
    `CHK(ready_busy_flag_o, 1'b1)
    `CHK(standby_o, 1'b0)
    host.bit_out(1'b1);
    host.bit_out(1'b0);
    host.set_wp(1'b0);
    repeat (6) @(posedge clk_i);
    `CHK(wp_n_o, 1'b0)
    host.set_wp(1'b1);
    host.set_hold(1'b1);
    repeat (8) @(posedge clk_i);
    `CHK(paused_o, 1'b1)
    host.set_sck(1'b0);
    repeat (4) @(posedge clk_i);
    `CHK(paused_o, 1'b0)
    host.set_sck(1'b1);
    host.set_hold(1'b0);
    repeat (8) @(posedge clk_i);
    `CHK(paused_o, 1'b0)
    host.set_sck(1'b0);
    repeat (4) @(posedge clk_i);
    `CHK(paused_o, 1'b1)
    `CHK(nstb - n0, 4)
    busy_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(ready_busy_flag_o, 1'b0)
    host.desel();
    `CHK(n_wel, 1)
    `CHK(n_abt, 1)
    host.set_hold(1'b1);
  endtask

  task automatic results();
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence: reset, corner table, random frames, pause
  initial begin
    logic [7:0] opc;
    nrst_i = 1'b0;
    busy_i = 1'b0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK(standby_o, 1'b1)
    `CHK(deep_pd_o, 1'b0)
    mon_on = 1'b1;
    for (int i = 0; i < NT; i++) run_case(t_opc[i], t_nb[i], t_bsy[i]);
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      opc  = (seed[1:0] == 2'h0) ? SFPH_OPC_POWERDOWN : (seed[1:0] == 2'h1) ? SFPH_OPC_RESUME : seed[15:8];
      run_case(opc, t_nbr[seed[3:2]], seed[4] & ~deep_exp);
    end
    if (deep_exp) run_case(SFPH_OPC_RESUME, 8, 1'b0);
    pause_case();
    results();
  end

  // watchdog sized well past the roughly 11k cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    results();
  end
endmodule
`undef CHK
`default_nettype wire

// File: tb/sfph_host.sv
// spi host model that drives the pins of the flash power and pause controller
`timescale 1ns/1ps
`default_nettype none
module sfph_host #(
  parameter int GAP_CYC = 320
) (
  input  wire logic clk_i,
  output var  logic cs_n_o,
  output var  logic sck_o,
  output wire logic si_o,
  output var  logic hold_n_o,
  output var  logic wp_n_o
);
  logic dat_reg;
  logic tog_reg;

  // =====================================================================
  // data line
  // a deselected data line toggles each cycle so a stale bit never looks valid
  assign si_o = cs_n_o ? tog_reg : dat_reg;

  // idle pins: deselected, clock parked low, pause and protect released
  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    hold_n_o = 1'b1;
    wp_n_o   = 1'b1;
    dat_reg  = 1'b0;
    tog_reg  = 1'b0;
  end

  // junk pattern source for the released data line
  always @(posedge clk_i) begin
    tog_reg <= ~tog_reg;
  end

  // =====================================================================
  // pin tasks, every change lands just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic set_sck(input logic v);
    sck_o <= v;
    tick(4);
  endtask

  task automatic set_hold(input logic v);
    hold_n_o <= v;
    tick(1);
  endtask

  task automatic set_wp(input logic v);
    wp_n_o <= v;
    tick(1);
  endtask

  task automatic sel();
    cs_n_o <= 1'b0;
    tick(4);
  endtask

  // one bit: data set in the low phase, 40 ns low then 40 ns high
  task automatic bit_out(input logic b);
    dat_reg <= b;
    sck_o   <= 1'b0;
    tick(4);
    sck_o <= 1'b1;
    tick(4);
  endtask

  // park the clock, deselect, then hold off long enough for entry or exit
  task automatic desel();
    sck_o <= 1'b0;
    tick(4);
    cs_n_o <= 1'b1;
    tick(GAP_CYC);
  endtask

  // whole frame, msb first; nb need not be a whole byte count
  task automatic frame(input logic [15:0] d, input int nb);
    sel();
    for (int i = 0; i < nb; i++) bit_out(d[15 - i]);
    desel();
  endtask
endmodule
`default_nettype wire

// File: verilog/sfph_ctrl.sv
// power-state and pause controller of the serial flash, top module
// How it works
// R1 - standby when deselected and not busy
// R2 - deep power-down ignores all but resume
// R3 - opcode B9h then deselect enters deep power-down
// R4 - partial byte at deselect keeps standby
// R5 - power-up always lands in standby
// R6 - power-down ignored while program or erase
// R7 - opcode ABh then deselect returns to standby
// R8 - bad resume framing stays in deep
// R9 - pause never stops program or erase
// R10 - pause starts selected, at clock low
// R11 - paused while pause and select held
// R12 - paused: output floats, clock and data ignored
// R13 - pause ends at clock low
// R14 - deselect during pause aborts, clears write enable
// R15 - ready/busy flag follows internal operation
// R16 - host waits entry/exit time before next command
`timescale 1ns/1ps
`default_nettype none
module sfph_ctrl (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  input  wire logic wp_n_i,
  input  wire logic busy_i,
  input  wire logic so_data_i,
  input  wire logic so_en_i,
  output var  logic so_o,
  output var  logic so_oe_n_o,
  output var  logic core_bit_stb_o,
  output var  logic core_bit_o,
  output var  logic core_frame_end_o,
  output var  logic wp_n_o,
  output var  logic standby_o,
  output var  logic deep_pd_o,
  output var  logic paused_o,
  output var  logic ready_busy_flag_o,
  output var  logic wel_clear_o,
  output var  logic op_abort_o
);
  import sfph_pkg::*;

  // =====================================================================
  // reset release
  logic rst_q1_reg;
  logic rst_n;

  // async assert, sync release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n      <= rst_q1_reg;
    end
  end

  // =====================================================================
  // pin synchronisation and edges
  logic [4:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       hold_s;
  logic       wp_s;
  logic       cs_prev_reg;
  logic       sck_prev_reg;
  logic       cs_prev_next;
  logic       sck_prev_next;

  sfph_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     ({wp_n_i, hold_n_i, si_i, sck_i, cs_n_i}),
    .q_o     (pins_s)
  );

  assign cs_s   = pins_s[SFPH_PIN_CS];
  assign sck_s  = pins_s[SFPH_PIN_SCK];
  assign si_s   = pins_s[SFPH_PIN_SI];
  assign hold_s = pins_s[SFPH_PIN_HOLD];
  assign wp_s   = pins_s[SFPH_PIN_WP];

  // edge memory of the synchronised select and clock
  always_comb begin
    cs_prev_next  = cs_s;
    sck_prev_next = sck_s;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg  <= cs_prev_next;
      sck_prev_reg <= sck_prev_next;
    end
  end

  logic cs_act;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  assign cs_act   = ~cs_s;
  assign cs_fall  = cs_prev_reg & ~cs_s;
  assign cs_rise  = ~cs_prev_reg & cs_s;
  assign sck_rise = sck_s & ~sck_prev_reg;

  // =====================================================================
  // pause
  logic paused_reg;
  logic paused_next;
  logic hold_abort;
  logic bit_stb;

  // while selected, pause level only changes with the clock low and the high phase defers it; deselect clears it at once
  always_comb begin
    paused_next = paused_reg;
    if (!cs_act) begin
      paused_next = 1'b0; // R10
    end else if (!sck_s) begin
      paused_next = ~hold_s; // R10 R13
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      paused_reg <= 1'b0;
    end else begin
      paused_reg <= paused_next; // R11
    end
  end

  // deselect with pause still asserted kills the frame
  assign hold_abort = cs_rise & ~hold_s; // R14
  // clock edges are dropped while paused
  assign bit_stb    = sck_rise & cs_act & ~paused_reg; // R12

  // =====================================================================
  // opcode capture
  logic [7:0] opcode;
  logic       opc_done;
  logic       aligned;

  sfph_opc u_opc (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n),
    .frame_start_i (cs_fall),
    .bit_stb_i     (bit_stb),
    .bit_i         (si_s),
    .opcode_o      (opcode),
    .opc_done_o    (opc_done),
    .aligned_o     (aligned)
  );

  logic pd_ok;
  logic res_ok;
  // full opcode, byte boundary, no abort; busy blocks power-down only
  assign pd_ok  = opc_done & aligned & ~hold_abort & ~busy_i
                  & (opcode == SFPH_OPC_POWERDOWN); // R3 R4 R6
  assign res_ok = opc_done & aligned & ~hold_abort
                  & (opcode == SFPH_OPC_RESUME); // R7 R8

  // =====================================================================
  // power state machine
  sfph_pwr_t  pwr_reg;
  sfph_pwr_t  pwr_next;
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;

  // entry and exit counters stand for the device's settle times
  always_comb begin
    pwr_next = pwr_reg;
    cnt_next = cnt_reg;
    unique case (pwr_reg)
      SFPH_PWR_STANDBY: begin
        if (cs_rise && pd_ok) begin
          pwr_next = SFPH_PWR_ENTER; // R3
          cnt_next = SFPH_ENTRY_LOAD;
        end
      end
      SFPH_PWR_ENTER: begin
        if (cnt_reg == SFPH_CNT_RST) begin
          pwr_next = SFPH_PWR_DEEP;
        end else begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      SFPH_PWR_DEEP: begin
        if (cs_rise && res_ok) begin
          pwr_next = SFPH_PWR_EXIT; // R7
          cnt_next = SFPH_EXIT_LOAD;
        end
      end
      SFPH_PWR_EXIT: begin
        if (cnt_reg == SFPH_CNT_RST) begin
          pwr_next = SFPH_PWR_STANDBY;
        end else begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      default: begin
        pwr_next = SFPH_PWR_RST;
        cnt_next = SFPH_CNT_RST;
      end
    endcase
  end

  // power-up and reset never land in deep power-down
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= SFPH_PWR_RST; // R5
      cnt_reg <= SFPH_CNT_RST;
    end else begin
      pwr_reg <= pwr_next;
      cnt_reg <= cnt_next;
    end
  end

  // =====================================================================
  // registered outputs
  logic so_next;
  logic so_oe_n_next;
  logic core_stb_next;
  logic core_bit_next;
  logic core_end_next;
  logic standby_next;
  logic deep_next;
  logic rdy_next;
  logic wel_clr_next;
  logic abort_next;
  logic live;

  // core sees the link only in normal power; deep mode drops every command
  assign live = (pwr_reg == SFPH_PWR_STANDBY); // R2

  always_comb begin
    so_next       = so_data_i;
    so_oe_n_next  = ~(cs_act & ~paused_reg & live & so_en_i); // R12
    core_stb_next = bit_stb & live; // R2
    core_bit_next = si_s;
    core_end_next = cs_rise & live;
    standby_next  = live & cs_s & ~busy_i; // R1
    deep_next     = (pwr_reg == SFPH_PWR_DEEP);
    rdy_next      = busy_i; // R9 R15
    wel_clr_next  = hold_abort & live; // R14
    abort_next    = hold_abort & live; // R14
  end

  // wp follows the pin even while paused
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      so_o              <= 1'b0;
      so_oe_n_o         <= 1'b1;
      core_bit_stb_o    <= 1'b0;
      core_bit_o        <= 1'b0;
      core_frame_end_o  <= 1'b0;
      wp_n_o            <= 1'b1;
      standby_o         <= 1'b0;
      deep_pd_o         <= 1'b0;
      paused_o          <= 1'b0;
      ready_busy_flag_o <= 1'b0;
      wel_clear_o       <= 1'b0;
      op_abort_o        <= 1'b0;
    end else begin
      so_o              <= so_next;
      so_oe_n_o         <= so_oe_n_next;
      core_bit_stb_o    <= core_stb_next;
      core_bit_o        <= core_bit_next;
      core_frame_end_o  <= core_end_next;
      wp_n_o            <= wp_s;
      standby_o         <= standby_next;
      deep_pd_o         <= deep_next;
      paused_o          <= paused_reg;
      ready_busy_flag_o <= rdy_next;
      wel_clear_o       <= wel_clr_next;
      op_abort_o        <= abort_next;
    end
  end

  // =====================================================================
  // assertions
  localparam int ENTRY_BOUND = SFPH_ENTRY_CYC + 2;
  localparam int EXIT_BOUND  = SFPH_EXIT_CYC + 2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  standby_flag_a: assert property ( // R1
    live && cs_s && !busy_i |=> standby_o)
    else $error("standby flag missing");
  deep_ignore_a: assert property ( // R2
    pwr_reg == SFPH_PWR_DEEP |=> !core_bit_stb_o && so_oe_n_o)
    else $error("command passed in deep power-down");
  pd_entry_a: assert property ( // R3
    live && cs_rise && pd_ok |-> ##[1:ENTRY_BOUND] deep_pd_o)
    else $error("deep power-down not reached in time");
  pd_misalign_a: assert property ( // R4
    live && cs_rise && !aligned |=> pwr_reg == SFPH_PWR_STANDBY)
    else $error("misaligned power-down accepted");
  reset_standby_a: assert property ( // R5
    !$past(rst_n) |-> pwr_reg == SFPH_PWR_STANDBY && !deep_pd_o)
    else $error("not in standby after reset");
  pd_busy_a: assert property ( // R6
    live && cs_rise && busy_i |=> pwr_reg == SFPH_PWR_STANDBY)
    else $error("power-down taken while busy");
  resume_a: assert property ( // R7
    pwr_reg == SFPH_PWR_DEEP && cs_rise && res_ok
    |-> ##[1:EXIT_BOUND] pwr_reg == SFPH_PWR_STANDBY)
    else $error("resume did not return to standby");
  resume_abort_a: assert property ( // R8
    pwr_reg == SFPH_PWR_DEEP && cs_rise && !res_ok |=> pwr_reg == SFPH_PWR_DEEP)
    else $error("bad resume left deep power-down");
  pause_busy_a: assert property ( // R9
    paused_reg && busy_i |=> ready_busy_flag_o)
    else $error("pause hid busy");
  pause_start_a: assert property ( // R10
    cs_act && !sck_s && !hold_s |=> paused_reg ##1 paused_o)
    else $error("pause did not start at clock low");
  pause_keep_a: assert property ( // R11
    paused_reg && cs_act && !hold_s |=> paused_reg)
    else $error("pause dropped early");
  pause_float_a: assert property ( // R12
    paused_reg |=> so_oe_n_o && !core_bit_stb_o)
    else $error("output driven while paused");
  pause_end_a: assert property ( // R13
    !sck_s && hold_s |=> !paused_reg)
    else $error("pause did not end at clock low");
  hold_abort_a: assert property ( // R14
    live && cs_rise && !hold_s |=> wel_clear_o && op_abort_o ##1 !wel_clear_o)
    else $error("deselect in pause did not abort");

  pd_cycle_c: cover property (live && cs_rise && pd_ok ##[1:ENTRY_BOUND] deep_pd_o);
  resume_c: cover property (pwr_reg == SFPH_PWR_DEEP && cs_rise && res_ok);
  pause_c: cover property (!paused_reg ##1 paused_reg ##[1:50] !paused_reg);
  hold_abort_c: cover property (live && hold_abort);
endmodule
`default_nettype wire

// File: verilog/sfph_opc.sv
// opcode capture and byte-boundary tracking for one frame
`timescale 1ns/1ps
`default_nettype none
module sfph_opc (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       frame_start_i,
  input  wire logic       bit_stb_i,
  input  wire logic       bit_i,
  output var  logic [7:0] opcode_o,
  output var  logic       opc_done_o,
  output var  logic       aligned_o
);
  import sfph_pkg::*;

  // =====================================================================
  // state
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [7:0] opc_next;
  logic       done_next;

  // only the first byte is kept, later bytes just move the counter
  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    opc_next   = opcode_o;
    done_next  = opc_done_o;
    if (frame_start_i) begin
      shift_next = SFPH_BYTE_RST;
      cnt_next   = SFPH_BCNT_RST;
      opc_next   = SFPH_BYTE_RST;
      done_next  = 1'b0;
    end else if (bit_stb_i) begin
      shift_next = {shift_reg[6:0], bit_i};
      cnt_next   = cnt_reg + 3'h1;
      if (cnt_reg == SFPH_BCNT_LAST && !opc_done_o) begin
        opc_next  = shift_next;
        done_next = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg  <= SFPH_BYTE_RST;
      cnt_reg    <= SFPH_BCNT_RST;
      opcode_o   <= SFPH_BYTE_RST;
      opc_done_o <= 1'b0;
    end else begin
      shift_reg  <= shift_next;
      cnt_reg    <= cnt_next;
      opcode_o   <= opc_next;
      opc_done_o <= done_next;
    end
  end

  // a count of zero means the frame sits on a byte boundary
  assign aligned_o = (cnt_reg == SFPH_BCNT_RST);
endmodule
`default_nettype wire

// File: verilog/sfph_sync.sv
// two-flop synchronisers for the link pins
`timescale 1ns/1ps
`default_nettype none
module sfph_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] d_i,
  output var  logic [4:0] q_o
);
  import sfph_pkg::*;

  // =====================================================================
  // per bit: first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < SFPH_NPINS; gi++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic q_next;
      // next values
      always_comb begin
        meta_next = d_i[gi];
        q_next    = meta_reg;
      end
      // idle level at reset keeps false edges away
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_reg <= SFPH_PINS_RST[gi];
          q_o[gi]  <= SFPH_PINS_RST[gi];
        end else begin
          meta_reg <= meta_next;
          q_o[gi]  <= q_next;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
